/* File: core/cso_chip_select.v */
// Chip-select option decoding with AHB-Lite register access and discrete output
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "cso_regs.vh"

// Contract
// - Direction field gates read/write assertion
// - Strobe bit picks address or data strobe
// - Codes 0-13 give that many wait states
// - Code 1110 ends access in two cycles
// - Space field restricts matched address space
// - CPU space compares acknowledge level lines
// - Level zero matches any; else exact level
// - In CPU space the level field gates the whole match: select, acknowledge and autovector
// - CPU space plus autovector bit autovectors
// - Discrete pins driven from output register
// - Bit 7 reads zero; others reset one
module cso_chip_select (
  // System
  input  wire        clk_sys,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // External bus cycle (pins)
  input  wire [23:0] bus_addr,
  input  wire        bus_rw,
  input  wire [2:0]  bus_fc,
  input  wire        bus_as_b,
  input  wire        bus_ds_b,
  input  wire        bus_iack,
  input  wire [1:0]  size_acknowledge_in_b,
  // Chip-select outputs
  output reg         cs_b,
  output reg  [1:0]  size_acknowledge_b,
  output reg         autovector_request_b,
  output reg  [6:0]  chip_select_discrete_output_pin
);
  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_m_q;
  reg rst_s_q;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // Bit positions inside the synchroniser word, lowest first
  localparam PIN_W    = 24 + 1 + 3 + 1 + 1 + 1 + 2;
  localparam P_ACK_LO = 0;
  localparam P_ACK_HI = 1;
  localparam P_IACK   = 2;
  localparam P_DS     = 3;
  localparam P_AS     = 4;
  localparam P_FC_LO  = 5;
  localparam P_FC_HI  = 7;
  localparam P_RW     = 8;
  localparam P_A_LO   = 9;
  wire [PIN_W-1:0] pin_s;
  cso_sync2 #(.W(PIN_W)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_s_q),
    .d       ({bus_addr, bus_rw, bus_fc, ~bus_as_b, ~bus_ds_b, bus_iack, ~size_acknowledge_in_b}),
    .q       (pin_s)
  );
  wire [23:0] a_s    = pin_s[PIN_W-1:P_A_LO];
  wire        rw_s   = pin_s[P_RW];
  wire [2:0]  fc_s   = pin_s[P_FC_HI:P_FC_LO];
  wire        as_s   = pin_s[P_AS];
  wire        ds_s   = pin_s[P_DS];
  wire        iack_s = pin_s[P_IACK];
  // Either acknowledge line ends the cycle, whatever the port width
  wire        ext_s  = |pin_s[P_ACK_HI:P_ACK_LO];

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  reg [`CSO_OPT_W-1:0]    opt_q;
  reg                     busy_q;
  reg [`CSO_BASE_W-1:0]   base_q;
  reg [`CSO_DOUT_W-1:0]   dout_q;
  reg [`CSO_DOUT_W-1:0]   assign_q;
  reg                     wr_pend_q;
  reg [`CSO_ADDR_W-1:0]   wr_addr_q;

  // Zero-wait slave: every transfer answers OKAY in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  wire take = hsel && hready && htrans == `CSO_HTRANS_NONSEQ;
  wire [`CSO_ADDR_W-1:0] a_off = haddr[`CSO_ADDR_W-1:0];

  function [31:0] reg_read;
    input [`CSO_ADDR_W-1:0] off;
    begin
      if (off == `CSO_OFS_OPTION) begin
        reg_read = {18'h00000, opt_q};
      end else if (off == `CSO_OFS_BASE) begin
        reg_read = {19'h00000, base_q};
      end else if (off == `CSO_OFS_DISCRETE) begin
        reg_read = {25'h0000000, dout_q};
      end else if (off == `CSO_OFS_ASSIGN) begin
        reg_read = {25'h0000000, assign_q};
      end else if (off == `CSO_OFS_STATUS) begin
        reg_read = {29'h00000000, autovector_request_b, cs_b, busy_q};
      end else begin
        reg_read = 32'h00000000;
      end
    end
  endfunction

  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`CSO_ADDR_W{1'b0}};
      hrdata    <= 32'h00000000;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        wr_addr_q <= a_off;
      end
      if (take && !hwrite) begin
        hrdata <= reg_read(a_off);
      end
    end
  end

  // ----------------------------------------------------------------
  // Register write strobes
  // ----------------------------------------------------------------
  // A write lands one cycle after its address phase, while hwdata stands
  reg we_opt;
  reg we_base;
  reg we_dout;
  reg we_assign;
  always @* begin
    we_opt    = 1'b0;
    we_base   = 1'b0;
    we_dout   = 1'b0;
    we_assign = 1'b0;
    if (wr_pend_q) begin
      if (wr_addr_q == `CSO_OFS_OPTION) begin
        we_opt = 1'b1;
      end else if (wr_addr_q == `CSO_OFS_BASE) begin
        we_base = 1'b1;
      end else if (wr_addr_q == `CSO_OFS_DISCRETE) begin
        we_dout = 1'b1;
      end else if (wr_addr_q == `CSO_OFS_ASSIGN) begin
        we_assign = 1'b1;
      end
    end
  end

  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      opt_q <= `CSO_OPT_RESET;
    end else if (we_opt) begin
      opt_q <= hwdata[`CSO_OPT_W-1:0];
    end
  end

  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      base_q <= `CSO_BASE_RESET;
    end else if (we_base) begin
      base_q <= hwdata[`CSO_BASE_W-1:0];
    end
  end

  // Bit 7 has no storage, so a write to it is simply dropped
  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      dout_q <= `CSO_DOUT_RESET;
    end else if (we_dout) begin
      dout_q <= hwdata[`CSO_DOUT_W-1:0];
    end
  end

  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      assign_q <= `CSO_ASSIGN_RESET;
    end else if (we_assign) begin
      assign_q <= hwdata[`CSO_DOUT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Option fields
  // ----------------------------------------------------------------
  wire       o_autovector_request  = opt_q[`CSO_OPT_AUTOVECTOR_REQUEST];
  wire [2:0] o_level = opt_q[`CSO_OPT_LEVEL_HI:`CSO_OPT_LEVEL_LO];
  wire [1:0] o_space = opt_q[`CSO_OPT_SPACE_HI:`CSO_OPT_SPACE_LO];
  wire [3:0] o_ack   = opt_q[`CSO_OPT_ACK_HI:`CSO_OPT_ACK_LO];
  wire       o_strobe_timing_select  = opt_q[`CSO_OPT_STROBE_TIMING_SELECT];
  wire [1:0] o_dir   = opt_q[`CSO_OPT_DIR_HI:`CSO_OPT_DIR_LO];

  // ----------------------------------------------------------------
  // Cycle match
  // ----------------------------------------------------------------
  // Function code 7 marks CPU space; 5/6 supervisor, 1/2 user
  wire sp_cpu   = fc_s == 3'h7;
  wire sp_super = fc_s == 3'h5 || fc_s == 3'h6;
  wire sp_user  = fc_s == 3'h1 || fc_s == 3'h2;

  wire base_hit = a_s[23:11] == base_q;

  reg dir_ok;
  reg space_ok;
  always @* begin
    case (o_dir)
      `CSO_DIR_READ:  dir_ok = rw_s;
      `CSO_DIR_WRITE: dir_ok = !rw_s;
      `CSO_DIR_BOTH:  dir_ok = 1'b1;
      default:        dir_ok = 1'b0;
    endcase
    case (o_space)
      `CSO_SPACE_CPU:   space_ok = sp_cpu;
      `CSO_SPACE_USER:  space_ok = sp_user;
      `CSO_SPACE_SUPER: space_ok = sp_super;
      default:          space_ok = sp_user || sp_super;
    endcase
  end

  // Level compare is part of the cycle match, so it gates recognition, acknowledge and autovector too
  wire is_cpu_cyc = o_space == `CSO_SPACE_CPU;
  wire level_ok = !is_cpu_cyc || (iack_s &&
                  (o_level == `CSO_LEVEL_ANY || a_s[3:1] == o_level));
  wire addr_ok  = is_cpu_cyc ? 1'b1 : base_hit;

  wire hit = as_s && addr_ok && dir_ok && space_ok && level_ok;

  // ----------------------------------------------------------------
  // Bus cycle tracking and termination
  // ----------------------------------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] st_q;
  reg [2:0] st_d;
  wire      int_ack;

  cso_ack_timer u_ack (
    .clk_sys  (clk_sys),
    .rst_b    (rst_s_q),
    .start    (st_q == ST_IDLE && hit),
    .busy     (as_s),
    .ack_code (o_ack),
    .ack_q    (int_ack)
  );

  always @* begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (hit) begin
          st_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!as_s) begin
          st_d = ST_IDLE;
        end else if (int_ack || (o_ack == `CSO_ACK_EXT && ext_s)) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!as_s) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Strobe-synchronised select: address strobe or data strobe qualifies
  wire strobe_ok = o_strobe_timing_select ? ds_s : as_s;
  wire cyc_act   = st_q != ST_IDLE;

  // ----------------------------------------------------------------
  // Discrete output pins
  // ----------------------------------------------------------------
  // Only one chip select is built, so every pin stays a discrete output
  wire [`CSO_DOUT_W-1:0] disc_d;
  genvar g;
  generate
    for (g = 0; g < `CSO_DOUT_W; g = g + 1) begin : g_disc
      assign disc_d[g] = dout_q[g];
    end
  endgenerate

  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q                            <= ST_IDLE;
      busy_q                          <= 1'b0;
      cs_b                            <= 1'b1;
      chip_select_discrete_output_pin <= `CSO_DOUT_RESET;
    end else begin
      st_q                            <= st_d;
      busy_q                          <= cyc_act;
      cs_b                            <= !(cyc_act && as_s && strobe_ok);
      chip_select_discrete_output_pin <= disc_d;
    end
  end

  // Held until the strobe drops so the master sees a stable acknowledge
  always @(posedge clk_sys or negedge rst_s_q) begin
    if (!rst_s_q) begin
      size_acknowledge_b   <= 2'h3;
      autovector_request_b <= 1'b1;
    end else if (!as_s) begin
      size_acknowledge_b   <= 2'h3;
      autovector_request_b <= 1'b1;
    end else if (st_q == ST_WAIT && int_ack) begin
      // External code 1111 never reaches here: the timer stays silent
      if (is_cpu_cyc && o_autovector_request) begin
        autovector_request_b <= 1'b0;
      end else begin
        size_acknowledge_b <= 2'h0;
      end
    end
  end
endmodule

/* File: include/cso_regs.vh */
// Register offsets, field positions, encodings and reset values for the chip-select option block
`ifndef CSO_REGS_VH
`define CSO_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSO_OFS_OPTION      12'h000
`define CSO_OFS_BASE        12'h004
`define CSO_OFS_DISCRETE    12'h008
`define CSO_OFS_ASSIGN      12'h00c
`define CSO_OFS_STATUS      12'h010
`define CSO_ADDR_W          12

// ----------------------------------------------------------------
// Option register fields
// ----------------------------------------------------------------
`define CSO_OPT_AUTOVECTOR_REQUEST        0
`define CSO_OPT_LEVEL_LO    1
`define CSO_OPT_LEVEL_HI    3
`define CSO_OPT_SPACE_LO    4
`define CSO_OPT_SPACE_HI    5
`define CSO_OPT_ACK_LO      6
`define CSO_OPT_ACK_HI      9
`define CSO_OPT_STROBE_TIMING_SELECT        10
`define CSO_OPT_DIR_LO      11
`define CSO_OPT_DIR_HI      12
`define CSO_OPT_SYNC        13
`define CSO_OPT_W           14
`define CSO_OPT_RESET       14'h0000

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define CSO_DIR_RSVD        2'h0
`define CSO_DIR_READ        2'h1
`define CSO_DIR_WRITE       2'h2
`define CSO_DIR_BOTH        2'h3
`define CSO_SPACE_CPU       2'h0
`define CSO_SPACE_USER      2'h1
`define CSO_SPACE_SUPER     2'h2
`define CSO_SPACE_EITHER    2'h3
`define CSO_ACK_FAST        4'he
`define CSO_ACK_EXT         4'hf
`define CSO_LEVEL_ANY       3'h0
`define CSO_FAST_CYCLES     4'h2

// ----------------------------------------------------------------
// Base, discrete output and pin assignment
// ----------------------------------------------------------------
`define CSO_BASE_W          13
`define CSO_BASE_RESET      13'h0000
`define CSO_DOUT_W          7
`define CSO_DOUT_RESET      7'h7f
`define CSO_ASSIGN_RESET    7'h00
`define CSO_HTRANS_NONSEQ   2'h2

`endif

/* File: core/cso_ack_timer.v */
// Wait-state counter producing the internal termination for a selected cycle
`timescale 1ns/10ps
module cso_ack_timer (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_b,
  // Cycle control
  input  wire       start,
  input  wire       busy,
  input  wire [3:0] ack_code,
  // Termination
  output reg        ack_q
);
  reg [3:0] cnt_q;
  reg       run_q;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Fast termination ends two cycles after start, same as wait code 1
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      ack_q <= 1'b0;
      if (!busy) begin
        run_q <= 1'b0;
      end else if (start && ack_code != `CSO_ACK_EXT) begin
        if (ack_code == `CSO_ACK_FAST) begin
          cnt_q <= `CSO_FAST_CYCLES - 4'h1;
        end else begin
          cnt_q <= ack_code;
        end
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == 4'h0) begin
          ack_q <= 1'b1;
          run_q <= 1'b0;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end
endmodule

/* File: core/cso_sync2.v */
// Two flip-flop synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module cso_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_b,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

/* File: verification/cso_chk.sv */
// Port-level assertions for the chip-select option block
`timescale 1ns/10ps
module cso_chk (
  // System
  input wire       clk_sys,
  input wire       rst_b,
  // Register bus
  input wire       hsel,
  input wire [1:0] htrans,
  input wire       hwrite,
  input wire       hreadyout,
  input wire       hresp,
  // Bus cycle
  input wire       bus_as_b,
  input wire       cs_b,
  input wire [1:0] size_acknowledge_b,
  input wire       autovector_request_b,
  input wire [6:0] chip_select_discrete_output_pin
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wire wr_req = hsel && hwrite && htrans == 2'h2;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Five idle samples cover the two-flop pin delay plus the output register
  sequence s_as_idle;
    bus_as_b [*5];
  endsequence
  sequence s_ack_held;
    (size_acknowledge_b == 2'h0 && !bus_as_b) [*3];
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout dropped");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_disc_cause: assert property ($changed(chip_select_discrete_output_pin) |->
    $past(wr_req, 1) || $past(wr_req, 2) || $past(wr_req, 3)) else $error("discrete pins moved unwritten");
  a_cs_idle: assert property (s_as_idle |-> cs_b) else $error("select without strobe");
  a_ack_idle: assert property (s_as_idle |-> size_acknowledge_b == 2'h3 && autovector_request_b)
    else $error("acknowledge without cycle");
  a_ack_pair: assert property (size_acknowledge_b == 2'h0 || size_acknowledge_b == 2'h3)
    else $error("acknowledge lines split");
  a_autovector_request_excl: assert property (!autovector_request_b |-> size_acknowledge_b == 2'h3)
    else $error("autovector with acknowledge");
  a_ack_held: assert property (s_ack_held |=> size_acknowledge_b == 2'h0)
    else $error("acknowledge dropped early");
endmodule

bind cso_chip_select cso_chk i_cso_chk (.*);

/* File: verification/cso_periph.sv */
// Behavioural peripheral answering with its own size acknowledge
`timescale 1ns/10ps
module cso_periph #(
  parameter DLY = 3
) (
  // System
  input wire       clk_sys,
  // Bus pins
  input wire       cs_b,
  input wire       bus_as_b,
  input wire       ext_en,
  output reg [1:0] size_acknowledge_in_b
);
  reg [3:0] cnt_q;
  initial begin
    cnt_q = 4'h0;
    size_acknowledge_in_b = 2'h3;
  end
  // Lines have pull-ups, so released means high
  always @(posedge clk_sys) begin
    if (bus_as_b || cs_b || !ext_en) begin
      cnt_q <= 4'h0;
      size_acknowledge_in_b <= 2'h3;
    end else if (cnt_q == DLY) begin
      size_acknowledge_in_b <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

/* File: verification/tb.sv */
// Directed bench for the chip-select option block
`timescale 1ns/10ps
`include "cso_regs.vh"
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  reg         clk_sys;
  reg         rst_b;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [2:0]  hsize;
  reg  [31:0] hwdata;
  wire        hready;
  wire        hreadyout;
  wire        hresp;
  wire [31:0] hrdata;
  reg  [23:0] bus_addr;
  reg         bus_rw;
  reg  [2:0]  bus_fc;
  reg         bus_as_b;
  reg         bus_ds_b;
  reg         bus_iack;
  reg         ext_en;
  wire [1:0]  size_acknowledge_in_b;
  wire        cs_b;
  wire [1:0]  size_acknowledge_b;
  wire        autovector_request_b;
  wire [6:0]  chip_select_discrete_output_pin;
  integer     bad_count;
  integer     num_checks;
  integer     t_cs;
  integer     t_ack;
  integer     t0;
  integer     i;
  integer     j;
  integer     k;
  reg         av_seen;
  reg  [31:0] rd;
  reg  [3:0]  c;
  reg  [2:0]  lv;
  assign hready = hreadyout;
  cso_chip_select i_cso_chip_select (
    .clk_sys                         (clk_sys),
    .rst_b                           (rst_b),
    .hsel                            (hsel),
    .haddr                           (haddr),
    .htrans                          (htrans),
    .hwrite                          (hwrite),
    .hsize                           (hsize),
    .hwdata                          (hwdata),
    .hready                          (hready),
    .hreadyout                       (hreadyout),
    .hresp                           (hresp),
    .hrdata                          (hrdata),
    .bus_addr                        (bus_addr),
    .bus_rw                          (bus_rw),
    .bus_fc                          (bus_fc),
    .bus_as_b                        (bus_as_b),
    .bus_ds_b                        (bus_ds_b),
    .bus_iack                        (bus_iack),
    .size_acknowledge_in_b           (size_acknowledge_in_b),
    .cs_b                            (cs_b),
    .size_acknowledge_b              (size_acknowledge_b),
    .autovector_request_b            (autovector_request_b),
    .chip_select_discrete_output_pin (chip_select_discrete_output_pin)
  );
  cso_periph i_cso_periph (
    .clk_sys               (clk_sys),
    .cs_b                  (cs_b),
    .bus_as_b              (bus_as_b),
    .ext_en                (ext_en),
    .size_acknowledge_in_b (size_acknowledge_in_b)
  );
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task ahb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= `CSO_HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // Sync mode bit stays 0, so autovector is only ever used asynchronously
  task opt(input [1:0] dir, input strobe_timing_select, input [3:0] ack, input [1:0] sp, input [2:0] lvl, input av);
    ahb(1'b1, `CSO_OFS_OPTION, {18'h0, 1'b0, dir, strobe_timing_select, ack, sp, lvl, av});
  endtask
  // One external cycle; data strobe falls dsd cycles after address strobe
  task cyc(input rw, input [2:0] fc, input iack, input [23:0] a, input integer dsd);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_rw <= rw;
    bus_fc <= fc;
    bus_iack <= iack;
    bus_as_b <= 1'b0;
    t_cs = 0;
    t_ack = 0;
    av_seen = 1'b0;
    for (k = 1; k <= 24; k++) begin
      @(posedge clk_sys);
      if (k == dsd)
        bus_ds_b <= 1'b0;
      #1;
      if (cs_b === 1'b0 && t_cs == 0)
        t_cs = k;
      if (size_acknowledge_b === 2'h0 && t_ack == 0)
        t_ack = k;
      if (autovector_request_b === 1'b0)
        av_seen = 1'b1;
    end
    @(posedge clk_sys);
    bus_as_b <= 1'b1;
    bus_ds_b <= 1'b1;
    bus_iack <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    complete_run;
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    bad_count = 0;
    num_checks = 0;
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    bus_addr = 24'h0;
    bus_rw = 1'b1;
    bus_fc = 3'h1;
    bus_as_b = 1'b1;
    bus_ds_b = 1'b1;
    bus_iack = 1'b0;
    ext_en = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Internal reset lingers two edges after release
    repeat (3) @(posedge clk_sys);
    ahb(1'b0, `CSO_OFS_DISCRETE, 32'h0);
    chk(rd, 32'h7f);
    chk(chip_select_discrete_output_pin, 32'h7f);
    ahb(1'b0, `CSO_OFS_OPTION, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, `CSO_OFS_STATUS, 32'h0);
    chk(rd, 32'h6);
    ahb(1'b1, `CSO_OFS_DISCRETE, 32'hff);
    ahb(1'b0, `CSO_OFS_DISCRETE, 32'h0);
    chk(rd, 32'h7f);
    ahb(1'b1, `CSO_OFS_DISCRETE, 32'h25);
    ahb(1'b0, `CSO_OFS_DISCRETE, 32'h0);
    chk(rd, 32'h25);
    chk(chip_select_discrete_output_pin, 32'h25);
    ahb(1'b1, `CSO_OFS_ASSIGN, 32'hff);
    ahb(1'b0, `CSO_OFS_ASSIGN, 32'h0);
    chk(rd, 32'h7f);
    ahb(1'b1, 12'h020, 32'hff);
    ahb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (i = 0; i < 4; i++)
      for (j = 0; j < 2; j++) begin
        opt(i[1:0], 1'b0, 4'h0, `CSO_SPACE_USER, 3'h5, 1'b0);
        cyc(j[0], 3'h1, 1'b0, 24'h000100, 1);
        chk(t_cs != 0, i == 3 || (i == 1 && j == 1) || (i == 2 && j == 0));
      end
    for (i = 0; i < 4; i++)
      for (j = 0; j < 3; j++) begin
        lv = j == 0 ? 3'h1 : j == 1 ? 3'h5 : 3'h7;
        opt(2'h3, 1'b0, 4'h0, i[1:0], 3'h0, 1'b0);
        cyc(1'b1, lv, lv == 3'h7, 24'h00000a, 1);
        chk(t_cs != 0, (i == 3 && j < 2) || (i == 2 && j == 1) || (i == 1 && j == 0) || (i == 0 && j == 2));
      end
    for (i = 0; i < 3; i++)
      for (j = 0; j < 2; j++) begin
        c = i == 0 ? 4'h0 : i == 1 ? 4'h3 : 4'h7;
        lv = j == 0 ? 3'h3 : 3'h5;
        opt(2'h3, 1'b0, 4'h0, `CSO_SPACE_CPU, c[2:0], 1'b1);
        cyc(1'b1, 3'h7, 1'b1, {20'h0, lv, 1'b0}, 1);
        chk(t_cs != 0, c == 0 || c[2:0] == lv);
        chk(av_seen, c == 0 || c[2:0] == lv);
      end
    opt(2'h3, 1'b0, 4'h0, `CSO_SPACE_USER, 3'h0, 1'b1);
    cyc(1'b1, 3'h1, 1'b0, 24'h000100, 1);
    chk({av_seen, t_ack != 0}, 2'h1);
    $display("test decode done");
    for (i = 0; i < 5; i++) begin
      c = i == 0 ? 4'h0 : i == 1 ? 4'h1 : i == 2 ? 4'h5 : i == 3 ? 4'hd : `CSO_ACK_FAST;
      opt(2'h3, 1'b0, c, `CSO_SPACE_USER, 3'h0, 1'b0);
      cyc(1'b0, 3'h1, 1'b0, 24'h000100, 1);
      if (i == 0)
        t0 = t_ack;
      chk(t_ack - t0, c == `CSO_ACK_FAST ? 1 : c);
    end
    chk(t0 != 0, 1);
    ext_en <= 1'b1;
    opt(2'h3, 1'b0, `CSO_ACK_EXT, `CSO_SPACE_USER, 3'h0, 1'b0);
    cyc(1'b1, 3'h1, 1'b0, 24'h000100, 1);
    chk({t_cs != 0, t_ack != 0}, 2'h2);
    ext_en <= 1'b0;
    for (i = 0; i < 2; i++) begin
      opt(2'h3, i[0], 4'h0, `CSO_SPACE_USER, 3'h0, 1'b0);
      cyc(1'b1, 3'h1, 1'b0, 24'h000100, 10);
      chk({t_cs != 0, t_cs > 10}, {1'b1, i[0]});
    end
    ahb(1'b1, `CSO_OFS_BASE, 32'h1);
    opt(2'h3, 1'b0, 4'h0, `CSO_SPACE_USER, 3'h0, 1'b0);
    cyc(1'b1, 3'h1, 1'b0, 24'h000100, 1);
    chk(t_cs != 0, 0);
    cyc(1'b1, 3'h1, 1'b0, 24'h000900, 1);
    chk(t_cs != 0, 1);
    $display("test timing done");
    complete_run;
  end
endmodule
